// ---- src/irq_map_cfg.svh ----
/*
 Interrupt line numbers, widths and synchroniser depth for the interrupt source mapper.
 Assumes it is included by the package and the design modules by its bare name.
*/
`ifndef IRQ_MAP_CFG_SVH
`define IRQ_MAP_CFG_SVH

// -----------------------------------------------------------------------------
// Processor interrupt line numbers
// -----------------------------------------------------------------------------
`define IRQ_CORE_TIMER     16
`define IRQ_DMA_DONE0      17
`define IRQ_WATCHDOG       18
`define IRQ_DMA_DONE1      19
`define IRQ_DMA_DONE2      20
`define IRQ_DMA_DONE3      21
`define IRQ_HOST_COMM      22
`define IRQ_ITMR           28
`define IRQ_UTMR           29
`define IRQ_HOST_EVENT     30
`define IRQ_PAD_EVENT      31
`define IRQ_FLASH_PORT     33
`define IRQ_DMA_FAULT0     34
`define IRQ_HOST_READ      35
`define IRQ_HOST_WRITE     36

// -----------------------------------------------------------------------------
// Widths and field positions
// -----------------------------------------------------------------------------
`define IRQ_LINE_WIDTH     41
`define DMA_CHANNELS       4
`define SCRATCH_LINES      16
`define PAD_CHANNELS       12
`define OUT_CHANNELS       3
`define HOST_EVENT_BIT     0
`define SYNC_STAGES        3

`endif

// ---- src/irq_map_pkg.sv ----
/*
 Types shared by the interrupt source mapper.
 Assumes the configuration header sits on the include path.
*/
`include "irq_map_cfg.svh"

package irq_map_pkg;
   // Host transport selected for end-of-access detection.
   typedef enum logic {
      host_mode_i2c,
      host_mode_spi
   } host_mode_t;

   typedef logic [`IRQ_LINE_WIDTH-1:0] irq_vec_t;
endpackage

// ---- src/irq_source_map.sv ----
/*
 Interrupt source mapper: routes and merges peripheral interrupt sources onto
 numbered processor interrupt lines.
 Assumes all peripheral sources run on sys_clk except the host chip select
 pin, which is asynchronous and synchronised here.
*/
// Contract
// - The core timer zero trigger drives processor line 16.
// - The watchdog trigger drives processor line 18.
// - DMA channel done lines 0 to 3 drive processor lines 17, 19, 20 and 21.
// - DMA done lines and the channel zero fault go straight to the processor, not through the merge logic; faults 1 to 3 leave on dma_fault_extra_irq.
// - The DMA channel zero fault drives processor line 34.
// - Line 22 fires on host I2C stop in I2C mode or host chip select deassertion in SPI mode.
// - A host write of one to timestamp request bit zero raises event line 30.
// - Sixteen device-to-host scratch read requests merge onto line 35.
// - Sixteen host-to-device scratch write requests merge onto line 36.
// - Command channel overflow feeds the combined host buffer error output.
// - Any output channel underflow feeds the same host buffer error output.
// - Flash port data request and done merge onto line 33.
// - The interval timer limit drives line 28.
// - The universal timer limit, compare or capture drives line 29.
// - Twelve pad event channels merge onto event line 31.
`timescale 1ns/100ps
`include "irq_map_cfg.svh"

module irq_source_map
   import irq_map_pkg::*;
(
   input  wire logic                         sys_clk,
   input  wire logic                         rst_b,
   input  wire logic                         core_timer_zero,
   input  wire logic                         watchdog_trigger,
   input  wire logic [`DMA_CHANNELS-1:0]     dma_channel_done_irq,
   input  wire logic [`DMA_CHANNELS-1:0]     dma_channel_fault_irq,
   input  wire logic                         host_mode,
   input  wire logic                         host_i2c_stop,
   input  wire logic                         host_chip_select_b,
   input  wire logic                         timestamp_request_write,
   input  wire logic [7:0]                   timestamp_request_data,
   input  wire logic [`SCRATCH_LINES-1:0]    device_to_host_scratch,
   input  wire logic [`SCRATCH_LINES-1:0]    host_to_device_scratch,
   input  wire logic                         command_channel_overflow,
   input  wire logic [`OUT_CHANNELS-1:0]     output_channel_underflow,
   input  wire logic                         flash_data_request,
   input  wire logic                         flash_done,
   input  wire logic                         itmr_limit,
   input  wire logic                         utmr_limit,
   input  wire logic                         utmr_compare,
   input  wire logic                         utmr_capture,
   input  wire logic [`PAD_CHANNELS-1:0]     pad_event_channel_source,
   output irq_vec_t                          cpu_irq,
   output logic [`DMA_CHANNELS-1:1]          dma_fault_extra_irq,
   output logic                              host_buffer_error_irq,
   output logic                              host_timestamp_event_irq,
   output logic                              pad_event_irq
);
   logic     rst_meta_b;
   logic     rst_sync_b;
   logic     cs_level;
   logic     cs_level_d;
   irq_vec_t next_irq;

   // Returns true when any bit of a source group is pending.
   function automatic logic any_pending(input logic [31:0] group);
      any_pending = |group;
   endfunction

   // -----------------------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------------------
   // Reset asserts at once but releases on the clock to avoid recovery hazards.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // -----------------------------------------------------------------------------
   // Host end-of-access detection
   // -----------------------------------------------------------------------------
   // The chip select pin comes from the host clock domain.
   pin_sync u_cs_sync (
      .sys_clk    (sys_clk),
      .rst_sync_b (rst_sync_b),
      .pin        (host_chip_select_b),
      .level      (cs_level)
   );

   // Delayed filtered level gives the rising edge, which is the deassertion.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cs_level_d <= 1'b1;
      end else begin
         cs_level_d <= cs_level;
      end
   end

   // -----------------------------------------------------------------------------
   // Line mapping
   // -----------------------------------------------------------------------------
   // Unlisted lines stay low; this block owns only the documented sources.
   always_comb begin
      next_irq = '0;
      next_irq[`IRQ_CORE_TIMER] = core_timer_zero;
      next_irq[`IRQ_WATCHDOG]   = watchdog_trigger;
      next_irq[`IRQ_DMA_DONE0]  = dma_channel_done_irq[0];
      next_irq[`IRQ_DMA_DONE1]  = dma_channel_done_irq[1];
      next_irq[`IRQ_DMA_DONE2]  = dma_channel_done_irq[2];
      next_irq[`IRQ_DMA_DONE3]  = dma_channel_done_irq[3];
      next_irq[`IRQ_DMA_FAULT0] = dma_channel_fault_irq[0];
      // A stop condition only counts in I2C mode, a select release only in SPI mode.
      if (host_mode_t'(host_mode) == host_mode_spi) begin
         next_irq[`IRQ_HOST_COMM] = cs_level & ~cs_level_d;
      end else begin
         next_irq[`IRQ_HOST_COMM] = host_i2c_stop;
      end
      next_irq[`IRQ_HOST_EVENT] = timestamp_request_write
                                  & timestamp_request_data[`HOST_EVENT_BIT];
      next_irq[`IRQ_HOST_READ]  =
         any_pending({16'h0000, device_to_host_scratch});
      next_irq[`IRQ_HOST_WRITE] =
         any_pending({16'h0000, host_to_device_scratch});
      next_irq[`IRQ_FLASH_PORT] = flash_data_request | flash_done;
      next_irq[`IRQ_ITMR]       = itmr_limit;
      next_irq[`IRQ_UTMR]       = utmr_limit | utmr_compare | utmr_capture;
      next_irq[`IRQ_PAD_EVENT]  =
         any_pending({20'h00000, pad_event_channel_source});
   end

   // -----------------------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------------------
   // Every line is registered once so all outputs but the SPI select release on line 22 share one cycle of latency.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cpu_irq <= '0;
      end else begin
         cpu_irq <= next_irq;
      end
   end

   // Remaining DMA fault lines bypass merging and leave the block directly.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         dma_fault_extra_irq <= 3'h0;
      end else begin
         dma_fault_extra_irq <= dma_channel_fault_irq[`DMA_CHANNELS-1:1];
      end
   end

   // Overflow and underflow share one error output; software reads sources to tell them apart.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         host_buffer_error_irq <= 1'b0;
      end else begin
         host_buffer_error_irq <= command_channel_overflow
                                  | (|output_channel_underflow);
      end
   end

   // Event-class copies for the event framework.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         host_timestamp_event_irq <= 1'b0;
         pad_event_irq            <= 1'b0;
      end else begin
         host_timestamp_event_irq <= next_irq[`IRQ_HOST_EVENT];
         pad_event_irq            <= next_irq[`IRQ_PAD_EVENT];
      end
   end
endmodule // irq_source_map

// ---- src/pin_sync.sv ----
/*
 Three-stage synchroniser for one pin input, with a change counted once the
 second and third stages agree.
 Assumes a single clock, the already released active-low reset and a pin that
 idles high, as an active-low select does.
*/
`timescale 1ns/100ps

module pin_sync (
   input  wire logic sys_clk,
   input  wire logic rst_sync_b,
   input  wire logic pin,
   output logic      level
);
   logic [2:0] stage;

   // -----------------------------------------------------------------------------
   // Capture chain
   // -----------------------------------------------------------------------------
   // The first stage feeds only the second, so metastability never reaches a gate.
   // The chain resets to the idle high level, so leaving reset shows no false edge.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         stage <= 3'h7;
      end else begin
         stage <= {stage[1:0], pin};
      end
   end

   // Filtered level only moves when the two settled stages agree.
   always_ff @(posedge sys_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         level <= 1'b1;
      end else if (stage[1] == stage[2]) begin
         level <= stage[2];
      end
   end
endmodule // pin_sync

// ---- tb/cpu_irq_sink.sv ----
/*
 Model of the processor's interrupt inputs: counts end-of-access pulses on line 22.
 Assumes the mapper's registered line vector on the same clock.
*/
`timescale 1ns/100ps
`include "irq_map_cfg.svh"
module cpu_irq_sink (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_b,
   input  wire logic [`IRQ_LINE_WIDTH-1:0] cpu_irq,
   output logic      [7:0]                 comm_count
);
   logic prev;
   // A line stuck high counts once only, so a missing fall shows as a lost pulse.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev       <= 1'b0;
         comm_count <= 8'h00;
      end else begin
         prev <= cpu_irq[`IRQ_HOST_COMM];
         if (cpu_irq[`IRQ_HOST_COMM] && !prev) comm_count <= comm_count + 8'h01;
      end
   end
endmodule // cpu_irq_sink

// ---- tb/irq_map_chk.sv ----
/*
 Checker for the interrupt source mapper, bound to its top module.
 Assumes sources stay low across reset release, as the bench drives them.
*/
`timescale 1ns/100ps
`include "irq_map_cfg.svh"
module irq_map_chk
   import irq_map_pkg::*;
(
   input wire logic                     sys_clk,
   input wire logic                     rst_b,
   input wire logic                     core_timer_zero,
   input wire logic                     watchdog_trigger,
   input wire logic [`DMA_CHANNELS-1:0] dma_channel_done_irq,
   input wire logic [`DMA_CHANNELS-1:0] dma_channel_fault_irq,
   input wire logic                     host_mode,
   input wire logic                     host_chip_select_b,
   input wire logic                     timestamp_request_write,
   input wire logic [7:0]               timestamp_request_data,
   input wire logic                     command_channel_overflow,
   input wire logic [`OUT_CHANNELS-1:0] output_channel_underflow,
   input wire logic [`PAD_CHANNELS-1:0] pad_event_channel_source,
   input wire irq_vec_t                 cpu_irq,
   input wire logic [`DMA_CHANNELS-1:1] dma_fault_extra_irq,
   input wire logic                     host_buffer_error_irq,
   input wire logic                     host_timestamp_event_irq,
   input wire logic                     pad_event_irq
);
   // --------------------
   // Line relations
   // --------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   AST_CORE_TIMER: assert property (cpu_irq[16] == $past(core_timer_zero))
      else $error("core timer line wrong");
   AST_WATCHDOG: assert property (cpu_irq[18] == $past(watchdog_trigger))
      else $error("watchdog line wrong");
   AST_DMA_DONE: assert property ({cpu_irq[21:19], cpu_irq[17]} == $past(dma_channel_done_irq))
      else $error("dma done lines wrong");
   AST_DMA_FAULT: assert property ({dma_fault_extra_irq, cpu_irq[34]} == $past(dma_channel_fault_irq))
      else $error("dma fault lines wrong");
   AST_STAMP: assert property (cpu_irq[30] == ($past(timestamp_request_write) && ($past(timestamp_request_data) & 8'h01) != 8'h00) && host_timestamp_event_irq == cpu_irq[30])
      else $error("timestamp event wrong");
   AST_BUF_ERR: assert property (host_buffer_error_irq == ($past(command_channel_overflow) || $past(output_channel_underflow) != '0))
      else $error("buffer error wrong");
   AST_PAD: assert property (cpu_irq[31] == ($past(pad_event_channel_source) != '0) && pad_event_irq == cpu_irq[31])
      else $error("pad event wrong");
   // The window is wider than the nominal five cycles to allow for pin phase.
   AST_SPI_END: assert property (host_mode && $rose(host_chip_select_b) |-> ##[3:6] cpu_irq[22] ##1 !cpu_irq[22])
      else $error("spi end pulse wrong");
   cover property (host_mode && $rose(host_chip_select_b));
   cover property (host_timestamp_event_irq);
   cover property (host_buffer_error_irq ##1 host_buffer_error_irq);
endmodule // irq_map_chk
bind irq_source_map irq_map_chk irq_map_chk_i (.*);

// ---- tb/tb.sv ----
/*
 Self-checking bench for the interrupt source mapper.
 Assumes the package, header, design and checker files are compiled first.
*/
`timescale 1ns/100ps
module tb;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        host_mode = 1'b0;
   logic        host_chip_select_b = 1'b1;
   logic [73:0] src = '0;
   logic core_timer_zero, watchdog_trigger, host_i2c_stop, timestamp_request_write, itmr_limit;
   logic command_channel_overflow, flash_data_request, flash_done, utmr_limit, utmr_compare;
   logic utmr_capture, host_buffer_error_irq, host_timestamp_event_irq, pad_event_irq;
   logic [3:0]  dma_channel_done_irq, dma_channel_fault_irq;
   logic [7:0]  timestamp_request_data, comm_count, c0;
   logic [15:0] device_to_host_scratch, host_to_device_scratch;
   logic [2:0]  output_channel_underflow, dma_fault_extra_irq;
   logic [11:0] pad_event_channel_source;
   logic [40:0] cpu_irq;
   logic [46:0] e;
   int          err_count = 0;
   int          cmp_count = 0;
   // Rows: first and last source bit, then the one or two output bits each must raise.
   int rows [19][4] = '{'{0,0,16,16}, '{1,1,18,18}, '{2,2,17,17}, '{3,3,19,19},
      '{4,4,20,20}, '{5,5,21,21}, '{6,6,34,34}, '{7,7,41,41}, '{8,8,42,42},
      '{9,9,43,43}, '{10,10,22,22}, '{20,35,35,35}, '{36,51,36,36},
      '{52,52,44,44}, '{53,55,44,44}, '{56,57,33,33}, '{58,58,28,28},
      '{59,61,29,29}, '{62,73,31,46}};
   wire  [46:0] outs = {pad_event_irq, host_timestamp_event_irq, host_buffer_error_irq,
                        dma_fault_extra_irq, cpu_irq};
   assign {pad_event_channel_source, utmr_capture, utmr_compare, utmr_limit, itmr_limit,
           flash_done, flash_data_request, output_channel_underflow, command_channel_overflow,
           host_to_device_scratch, device_to_host_scratch, timestamp_request_data,
           timestamp_request_write, host_i2c_stop, dma_channel_fault_irq, dma_channel_done_irq,
           watchdog_trigger, core_timer_zero} = src;
   irq_source_map irq_source_map_i (.*);
   cpu_irq_sink cpu_irq_sink_i (.*);
   // --------------------
   // Tasks
   // --------------------
   always #50 sys_clk = ~sys_clk;
   task automatic check(input logic [46:0] got, input logic [46:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Holds the sources two edges so the registered answer is settled at the negedge.
   task automatic apply(input logic [73:0] v);
      @(posedge sys_clk);
      src <= v;
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // --------------------
   // Sequence
   // --------------------
   initial begin
      int n;
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge sys_clk);
      foreach (rows[r]) begin
         for (int b = rows[r][0]; b <= rows[r][1]; b++) begin
            apply(74'h1 << b);
            e = (47'h1 << rows[r][2]) | (47'h1 << rows[r][3]);
            check(outs, e);
         end
      end
      apply(74'h3 << 11);
      check(outs, (47'h1 << 30) | (47'h1 << 45));
      apply((74'hfe << 12) | (74'h1 << 11));
      check(outs, 47'h0);
      apply(74'h1 << 12);
      check(outs, 47'h0);
      apply((74'h801 << 62) | (74'h1 << 55) | (74'h1 << 52));
      e = (47'h1 << 31) | (47'h1 << 46) | (47'h1 << 44);
      check(outs, e);
      apply((74'h800 << 62) | (74'h1 << 55));
      check(outs, e);
      c0 = comm_count;
      @(posedge sys_clk);
      host_mode <= 1'b1;
      host_chip_select_b <= 1'b0;
      apply(74'h1 << 10);
      check(outs, 47'h0);
      repeat (4) @(posedge sys_clk);
      host_chip_select_b <= 1'b1;
      for (n = 0; n < 10 && cpu_irq[22] !== 1'b1; n++) @(negedge sys_clk);
      if (n == 10) begin
         err_count++;
         tally_and_finish();
      end
      @(negedge sys_clk);
      check(outs, 47'h0);
      check({39'h0, comm_count}, {39'h0, c0 + 8'h01});
      @(posedge sys_clk);
      host_mode <= 1'b0;
      host_chip_select_b <= 1'b0;
      src <= '0;
      repeat (8) @(posedge sys_clk);
      host_chip_select_b <= 1'b1;
      repeat (8) @(negedge sys_clk);
      check({39'h0, comm_count}, {39'h0, c0 + 8'h01});
      apply({74{1'b1}});
      @(posedge sys_clk);
      rst_b <= 1'b0;
      @(negedge sys_clk);
      check(outs, 47'h0);
      @(posedge sys_clk);
      src <= '0;
      host_mode <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge sys_clk);
      apply(74'h1 << 58);
      check(outs, 47'h1 << 28);
      check({39'h0, comm_count}, 47'h0);
      tally_and_finish();
   end
endmodule // tb
